//--- core/pdms_top.sv
`timescale 1ns/100ps
module pdms_top
#(
    parameter int WAIT_UNIT = pdms_pkg::WAIT_UNIT_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sleep_exec,
    input wire logic irq_mask,
    input wire logic [3:0] external_irq_lines,
    input wire logic [5:0] wakeup_pin_lines,
    input wire logic external_init_pin_n,
    output pdms_pkg::pdms_mode_t power_mode,
    output logic cpu_clk_en,
    output logic periph_halt,
    output logic sub_clk_en,
    output logic core_reset,
    output logic irq_pending,
    output logic irq_wake,
    output logic indicator_output_pin_o,
    output logic indicator_output_pin_oe
);
    import pdms_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] pwr_a_r;
    logic [7:0] pwr_b_r;
    logic [7:0] irq_en_r;
    logic [7:0] irq_flag_r;
    logic [5:0] wkp_en_r;
    logic [5:0] wkp_flag_r;
    logic [7:0] tb_mode_r;
    logic [7:0] port_dir_r;
    logic [7:0] port_out_r;
    logic [10:0] pin_meta_r;
    logic [10:0] pin_sync_r;
    logic [10:0] pin_prev_r;
    logic [3:0] irq_rise;
    logic [5:0] wkp_rise;
    logic init_low;
    logic init_prev_r;
    logic [10:0] sub_div_r;
    logic [7:0] tb_count;
    logic tb_overflow;
    logic settle_done;
    logic settle_start;
    pdms_mode_t mode_r;
    pdms_mode_t mode_nxt;
    logic wake_hit;
    logic wr_ok;
    logic soft_clr;

    // ----------------------------------------------------------------
    // Decoding used by the register file and the request flags
    // ----------------------------------------------------------------
    function automatic logic hits(input logic [3:0] a, input logic [3:0] target, input logic s);
        hits = s && (a == target);
    endfunction

    function automatic logic [7:0] flag_update(input logic [7:0] cur, input logic [7:0] set,
                                               input logic [7:0] wdata, input logic clr);
        // Write zero clears; a set in the same cycle wins
        flag_update = (clr ? (cur & wdata) : cur) | set;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_meta_r <= 11'h400;
            pin_sync_r <= 11'h400;
            pin_prev_r <= 11'h400;
        end
        else
        begin
            pin_meta_r <= {external_init_pin_n, wakeup_pin_lines, external_irq_lines};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    assign irq_rise = pin_sync_r[3:0] & ~pin_prev_r[3:0];
    assign wkp_rise = pin_sync_r[9:4] & ~pin_prev_r[9:4];
    assign init_low = !pin_sync_r[10];
    // Sequencer, settle wait, control registers and flags restart while the init pin is low
    assign soft_clr = init_low;

    // ----------------------------------------------------------------
    // Subclock divider, never gated so the time base can wake us
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sub_div_r <= 11'h000;
            sub_clk_en <= 1'b0;
        end
        else
        begin
            sub_clk_en <= 1'b0;
            if (sub_div_r == 11'(SUB_DIV_CYCLES - 1))
            begin
                sub_div_r <= 11'h000;
                sub_clk_en <= 1'b1;
            end
            else
            begin
                sub_div_r <= sub_div_r + 11'h001;
            end
        end
    end

    pdms_timebase u_timebase
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sub_tick(sub_clk_en),
        .run(tb_mode_r[TB_ENABLE_BIT]),
        .rate_sel(tb_mode_r[2:0]),
        .count(tb_count),
        .overflow(tb_overflow)
    );

    pdms_settle #(.UNIT_CYCLES(WAIT_UNIT)) u_settle
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .start(settle_start),
        .abort(soft_clr),
        .wait_sel(pwr_a_r[WAIT_SEL_LSB +: 3]),
        .done(settle_done)
    );

    // ----------------------------------------------------------------
    // Wake decision
    // ----------------------------------------------------------------
    // Only enabled, unmasked requests count; anything else but a low init pin leaves us asleep
    assign wake_hit = !irq_mask && (
        (irq_flag_r[TICK_BIT] && irq_en_r[TICK_BIT]) ||
        |(irq_flag_r[3:0] & irq_en_r[3:0]) ||
        |(wkp_flag_r & wkp_en_r));
    assign irq_pending = (irq_flag_r[TICK_BIT] && irq_en_r[TICK_BIT]) ||
                         |(irq_flag_r[3:0] & irq_en_r[3:0]) ||
                         |(wkp_flag_r & wkp_en_r);

    // ----------------------------------------------------------------
    // Power-mode sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        mode_nxt = mode_r;
        case (mode_r)
            PDMS_ACTIVE:
            begin
                // Sleep instruction arrives only at an instruction boundary
                if (sleep_exec && pwr_b_r[LOW_SPEED_BIT] && pwr_b_r[DIRECT_BIT])
                begin
                    mode_nxt = PDMS_SUBACTIVE;
                end
            end
            PDMS_SUBACTIVE:
            begin
                if (sleep_exec && !pwr_b_r[LOW_SPEED_BIT] && pwr_b_r[DIRECT_BIT])
                begin
                    mode_nxt = PDMS_SETTLE;
                end
                else if (sleep_exec && !pwr_a_r[SW_STANDBY_BIT] && !pwr_b_r[DIRECT_BIT] &&
                         pwr_b_r[SLEEP_KIND_BIT] && pwr_b_r[LOW_SPEED_BIT])
                begin
                    mode_nxt = PDMS_SUBSLEEP;
                end
            end
            PDMS_SUBSLEEP:
            begin
                if (wake_hit)
                begin
                    mode_nxt = PDMS_SUBACTIVE;
                end
            end
            PDMS_SETTLE:
            begin
                if (settle_done)
                begin
                    mode_nxt = PDMS_ACTIVE;
                end
            end
            PDMS_INIT:
            begin
                mode_nxt = PDMS_ACTIVE;
            end
            default:
            begin
                mode_nxt = PDMS_ACTIVE;
            end
        endcase
    end

    assign settle_start = (mode_r == PDMS_SUBACTIVE) && (mode_nxt == PDMS_SETTLE);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_r <= PDMS_INIT;
        end
        else if (soft_clr)
        begin
            mode_r <= PDMS_INIT;
        end
        else
        begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_wake <= 1'b0;
            init_prev_r <= 1'b0;
            core_reset <= 1'b1;
        end
        else
        begin
            irq_wake <= (mode_r == PDMS_SUBSLEEP) && wake_hit && !soft_clr;
            init_prev_r <= init_low;
            // Core stays in reset while the pin is low and starts its exception after release
            core_reset <= init_low || init_prev_r;
        end
    end

    assign power_mode = mode_r;
    // Core clock stops in subsleep and during the oscillator settle
    assign cpu_clk_en = (mode_r == PDMS_ACTIVE) || (mode_r == PDMS_SUBACTIVE);
    assign periph_halt = (mode_r == PDMS_SUBSLEEP);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    // Writes are refused outside run modes so state sleeps unchanged
    assign wr_ok = reg_wr && cpu_clk_en;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pwr_a_r <= PWR_A_RST;
            pwr_b_r <= PWR_B_RST;
            irq_en_r <= REG_ZERO;
            wkp_en_r <= 6'h00;
            tb_mode_r <= TB_MODE_RST;
        end
        else if (soft_clr)
        begin
            pwr_a_r <= PWR_A_RST;
            pwr_b_r <= PWR_B_RST;
            irq_en_r <= REG_ZERO;
            wkp_en_r <= 6'h00;
            tb_mode_r <= TB_MODE_RST;
        end
        else
        begin
            if (hits(reg_addr, ADDR_PWR_A, wr_ok))
            begin
                pwr_a_r <= {reg_wdata[7:4], 4'h0};
            end
            if (hits(reg_addr, ADDR_PWR_B, wr_ok))
            begin
                pwr_b_r <= {reg_wdata[7:5], 5'h00};
            end
            if (hits(reg_addr, ADDR_IRQ_EN, wr_ok))
            begin
                irq_en_r <= reg_wdata & 8'h4f;
            end
            if (hits(reg_addr, ADDR_WKP_EN, wr_ok))
            begin
                wkp_en_r <= reg_wdata[5:0];
            end
            if (hits(reg_addr, ADDR_TB_MODE, wr_ok))
            begin
                tb_mode_r <= {4'h0, reg_wdata[3:0]};
            end
        end
    end

    // Request flags keep catching edges in every mode except while the init pin is low, which holds them clear
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_flag_r <= REG_ZERO;
            wkp_flag_r <= 6'h00;
        end
        else if (soft_clr)
        begin
            irq_flag_r <= REG_ZERO;
            wkp_flag_r <= 6'h00;
        end
        else
        begin
            irq_flag_r <= flag_update(irq_flag_r,
                                      {1'b0, tb_overflow, 2'b00, irq_rise},
                                      reg_wdata, hits(reg_addr, ADDR_IRQ_FLAG, wr_ok));
            wkp_flag_r <= 6'(flag_update({2'b00, wkp_flag_r}, {2'b00, wkp_rise},
                                         reg_wdata, hits(reg_addr, ADDR_WKP_FLAG, wr_ok)));
        end
    end

    // Port registers survive the init pin so the LED keeps its state
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            port_dir_r <= REG_ZERO;
            port_out_r <= REG_ZERO;
        end
        else
        begin
            if (hits(reg_addr, ADDR_PORT_DIR, wr_ok))
            begin
                port_dir_r <= reg_wdata;
            end
            if (hits(reg_addr, ADDR_PORT_OUT, wr_ok))
            begin
                port_out_r <= reg_wdata;
            end
        end
    end

    assign indicator_output_pin_o = port_out_r[IND_BIT];
    assign indicator_output_pin_oe = port_dir_r[IND_BIT];

    // ----------------------------------------------------------------
    // Read path, data one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata <= REG_ZERO;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                ADDR_PWR_A: reg_rdata <= pwr_a_r;
                ADDR_PWR_B: reg_rdata <= pwr_b_r;
                ADDR_IRQ_EN: reg_rdata <= irq_en_r;
                ADDR_IRQ_FLAG: reg_rdata <= irq_flag_r;
                ADDR_WKP_EN: reg_rdata <= {2'b00, wkp_en_r};
                ADDR_WKP_FLAG: reg_rdata <= {2'b00, wkp_flag_r};
                ADDR_TB_MODE: reg_rdata <= tb_mode_r;
                ADDR_TB_COUNT: reg_rdata <= tb_count;
                ADDR_PORT_DIR: reg_rdata <= port_dir_r;
                ADDR_PORT_OUT: reg_rdata <= port_out_r;
                ADDR_MODE_STAT: reg_rdata <= {5'h00, mode_r};
                default: reg_rdata <= REG_ZERO;
            endcase
        end
        else
        begin
            reg_rdata <= REG_ZERO;
        end
    end
endmodule

//--- pkg/pdms_pkg.sv
package pdms_pkg;

    // ----------------------------------------------------------------
    // Register map (8-bit data, one register per address)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_PWR_A = 4'h0;
    localparam logic [3:0] ADDR_PWR_B = 4'h1;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h2;
    localparam logic [3:0] ADDR_IRQ_FLAG = 4'h3;
    localparam logic [3:0] ADDR_WKP_EN = 4'h4;
    localparam logic [3:0] ADDR_WKP_FLAG = 4'h5;
    localparam logic [3:0] ADDR_TB_MODE = 4'h6;
    localparam logic [3:0] ADDR_TB_COUNT = 4'h7;
    localparam logic [3:0] ADDR_PORT_DIR = 4'h8;
    localparam logic [3:0] ADDR_PORT_OUT = 4'h9;
    localparam logic [3:0] ADDR_MODE_STAT = 4'ha;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SW_STANDBY_BIT = 7;
    localparam int WAIT_SEL_LSB = 4;
    localparam int SLEEP_KIND_BIT = 7;
    localparam int LOW_SPEED_BIT = 6;
    localparam int DIRECT_BIT = 5;
    localparam int TICK_BIT = 6;
    localparam int IND_BIT = 4;
    localparam int TB_ENABLE_BIT = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PWR_A_RST = 8'h00;
    localparam logic [7:0] PWR_B_RST = 8'h00;
    localparam logic [7:0] TB_MODE_RST = 8'h00;
    localparam logic [7:0] REG_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_MHZ = 50;
    localparam int SUBCLK_HZ = 32_768;
    localparam int SUB_DIV_CYCLES = CLK_HZ / SUBCLK_HZ;
    localparam int TB_PERIOD_MS = 500;
    localparam int TB_STEPS = 256;
    localparam int TB_PRESCALE = SUBCLK_HZ * TB_PERIOD_MS / 1000 / TB_STEPS;
    localparam int WAIT_STATES = 131_072;
    localparam int WAIT_REF_MHZ = 16;
    localparam int WAIT_REF_SEL = 4;
    localparam int WAIT_FULL_CYCLES = (WAIT_STATES * CLK_MHZ + WAIT_REF_MHZ - 1) / WAIT_REF_MHZ;
    localparam int WAIT_UNIT_CYCLES = WAIT_FULL_CYCLES >> WAIT_REF_SEL;

    typedef enum logic [2:0] {
        PDMS_ACTIVE,
        PDMS_SUBACTIVE,
        PDMS_SUBSLEEP,
        PDMS_SETTLE,
        PDMS_INIT
    } pdms_mode_t;

endpackage

//--- core/pdms_timebase.sv
`timescale 1ns/100ps
module pdms_timebase
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sub_tick,
    input wire logic run,
    input wire logic [2:0] rate_sel,
    output logic [7:0] count,
    output logic overflow
);
    import pdms_pkg::*;

    logic [6:0] pre_r;
    logic [6:0] pre_lim;

    // Faster rates shorten the prescaler; select 0 gives the half-second overflow
    assign pre_lim = 7'(TB_PRESCALE >> rate_sel);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pre_r <= 7'h00;
            count <= 8'h00;
            overflow <= 1'b0;
        end
        else
        begin
            overflow <= 1'b0;
            if (!run)
            begin
                pre_r <= 7'h00;
                count <= 8'h00;
            end
            else if (sub_tick)
            begin
                if (pre_r + 7'h01 >= pre_lim)
                begin
                    pre_r <= 7'h00;
                    count <= count + 8'h01;
                    overflow <= (count == 8'hff);
                end
                else
                begin
                    pre_r <= pre_r + 7'h01;
                end
            end
        end
    end
endmodule

//--- core/pdms_settle.sv
`timescale 1ns/100ps
module pdms_settle
#(
    parameter int UNIT_CYCLES = 25600
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [2:0] wait_sel,
    output logic done
);
    logic [31:0] left_r;
    logic busy_r;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            left_r <= 32'h0;
            busy_r <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (abort)
            begin
                busy_r <= 1'b0;
            end
            else if (start)
            begin
                left_r <= 32'(UNIT_CYCLES) << wait_sel;
                busy_r <= 1'b1;
            end
            else if (busy_r)
            begin
                if (left_r <= 32'h1)
                begin
                    busy_r <= 1'b0;
                    done <= 1'b1;
                end
                left_r <= left_r - 32'h1;
            end
        end
    end
endmodule

//--- verif/pdms_properties.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module pdms_checker
import pdms_pkg::*;
#(
    parameter int WAIT_UNIT = 4
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic sleep_exec,
    input wire logic irq_mask,
    input wire logic external_init_pin_n,
    input wire pdms_pkg::pdms_mode_t power_mode,
    input wire logic cpu_clk_en,
    input wire logic periph_halt,
    input wire logic sub_clk_en,
    input wire logic core_reset,
    input wire logic irq_pending,
    input wire logic irq_wake,
    input wire logic indicator_output_pin_o,
    input wire logic indicator_output_pin_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [7:0] a_r;
    logic [7:0] b_r;
    int gap_r;
    int set_r;
    // Shadow of the power control registers, cleared by any reset
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            a_r <= 8'h00;
            b_r <= 8'h00;
        end
        else if (core_reset)
        begin
            a_r <= 8'h00;
            b_r <= 8'h00;
        end
        else if (reg_wr && cpu_clk_en && reg_addr == ADDR_PWR_A)
            a_r <= reg_wdata;
        else if (reg_wr && cpu_clk_en && reg_addr == ADDR_PWR_B)
            b_r <= reg_wdata;
    end
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gap_r <= 0;
            set_r <= 0;
        end
        else
        begin
            gap_r <= sub_clk_en ? 1 : gap_r + 1;
            set_r <= (power_mode == PDMS_SETTLE) ? set_r + 1 : 0;
        end
    end
    a_direct_sub: assert property (power_mode == PDMS_ACTIVE && sleep_exec && b_r[LOW_SPEED_BIT]
        && b_r[DIRECT_BIT] |=> power_mode == PDMS_SUBACTIVE) else $error("no subactive entry");
    a_enter_subsleep: assert property (power_mode == PDMS_SUBACTIVE && sleep_exec && !a_r[7]
        && b_r[7:5] == 3'h6 |=> power_mode == PDMS_SUBSLEEP) else $error("no subsleep entry");
    a_settle_entry: assert property (power_mode == PDMS_SUBACTIVE && sleep_exec
        && !b_r[LOW_SPEED_BIT] && b_r[DIRECT_BIT] |=> power_mode == PDMS_SETTLE)
        else $error("no settle entry");
    a_halt_set: assert property (power_mode == PDMS_SUBSLEEP |-> periph_halt && !cpu_clk_en)
        else $error("peripherals not halted");
    a_port_hold: assert property (periph_halt && $past(periph_halt) |->
        $stable(indicator_output_pin_o) && $stable(indicator_output_pin_oe))
        else $error("port changed in subsleep");
    a_masked_stay: assert property (power_mode == PDMS_SUBSLEEP && irq_mask
        && external_init_pin_n |=> power_mode == PDMS_SUBSLEEP) else $error("masked wake");
    a_quiet_stay: assert property (power_mode == PDMS_SUBSLEEP && !irq_pending
        && external_init_pin_n |=> power_mode == PDMS_SUBSLEEP) else $error("spurious wake");
    a_wake_service: assert property (power_mode == PDMS_SUBSLEEP && !irq_mask && irq_pending
        |=> power_mode == PDMS_SUBACTIVE && irq_wake) else $error("wake not serviced");
    a_init_reset: assert property (!external_init_pin_n [*4] |-> core_reset
        && power_mode == PDMS_INIT) else $error("init pin ignored");
    a_dir_write: assert property (reg_wr && cpu_clk_en && reg_addr == ADDR_PORT_DIR
        |=> indicator_output_pin_oe == $past(reg_wdata[IND_BIT])) else $error("direction lost");
    a_subclk_free: assert property (gap_r <= SUB_DIV_CYCLES + 2)
        else $error("subclock gated");
    a_settle_len: assert property (set_r <= (WAIT_UNIT << 7) + 4)
        else $error("settle wait too long");
    c_wake: cover property (irq_wake);
    c_settle: cover property (power_mode == PDMS_SETTLE);
    c_init: cover property (core_reset && power_mode == PDMS_INIT);
endmodule
bind pdms_top pdms_checker #(.WAIT_UNIT(WAIT_UNIT)) chk_u (.*);

//--- verif/pdms_core_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Processor core stand-in
// ----------------------------------------------------------------
module pdms_core_model
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic go,
    input wire logic mask_req,
    input wire logic cpu_clk_en,
    input wire logic irq_wake,
    output logic sleep_exec,
    output logic irq_mask,
    output int wake_cnt
);
    // A halted core executes nothing, so no sleep is issued then
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sleep_exec <= 1'b0;
            irq_mask <= 1'b0;
            wake_cnt <= 0;
        end
        else
        begin
            sleep_exec <= go && cpu_clk_en;
            irq_mask <= mask_req;
            wake_cnt <= wake_cnt + int'(irq_wake);
        end
    end
endmodule

//--- verif/tb.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module tb;
import pdms_pkg::*;
localparam int WU = 4;
logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, init_n = 1'b1;
logic go = 1'b0, mask_req = 1'b0, cpu_clk_en, periph_halt, sub_clk_en, core_reset;
logic irq_pending, irq_wake, ind_o, ind_oe, sleep_exec, irq_mask;
logic [3:0] reg_addr = 4'h0, irq_l = 4'h0;
logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
logic [5:0] wkp_l = 6'h00;
pdms_mode_t power_mode;
int wake_cnt, err_count, checked, n, t, k;
int mdl[16];
logic [7:0] msk[16];
always #10 clk_sys = ~clk_sys;
pdms_top #(.WAIT_UNIT(WU)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_exec(sleep_exec), .irq_mask(irq_mask), .external_irq_lines(irq_l),
    .wakeup_pin_lines(wkp_l), .external_init_pin_n(init_n), .power_mode(power_mode),
    .cpu_clk_en(cpu_clk_en), .periph_halt(periph_halt), .sub_clk_en(sub_clk_en),
    .core_reset(core_reset), .irq_pending(irq_pending), .irq_wake(irq_wake),
    .indicator_output_pin_o(ind_o), .indicator_output_pin_oe(ind_oe));
pdms_core_model core_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .mask_req(mask_req),
    .cpu_clk_en(cpu_clk_en), .irq_wake(irq_wake), .sleep_exec(sleep_exec),
    .irq_mask(irq_mask), .wake_cnt(wake_cnt));
task automatic end_sim;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
        $display("FAIL %s expected %h seen %h", nm, e, g);
        err_count++;
    end
endtask
task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    mdl[a] = d & msk[a];
endtask
task automatic rd(input logic [3:0] a, input bit cmp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    if (cmp)
        chk("reg_rdata", mdl[a][7:0], v);
endtask
task automatic mode_is(input pdms_mode_t m);
    chk("power_mode", {5'h00, m}, {5'h00, power_mode});
endtask
task automatic sleep;
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
endtask
// Bounded so a stuck sequencer ends the run instead of hanging it
task automatic wait_mode(input pdms_mode_t m);
    n = 0;
    while (power_mode !== m && n < 5000)
    begin
        @(posedge clk_sys);
        #1 n++;
    end
    if (n == 5000)
    begin
        $display("FAIL power_mode expected %h seen %h", m, power_mode);
        err_count++;
        end_sim;
    end
endtask
initial
begin
    repeat (100000) @(posedge clk_sys);
    $display("FAIL run_length expected %h seen %h", 0, 1);
    err_count++;
    end_sim;
end
initial
begin
    msk = '{default: 8'h00};
    msk[0] = 8'hf0;
    msk[1] = 8'he0;
    msk[2] = 8'h4f;
    msk[4] = 8'h3f;
    msk[6] = 8'h0f;
    msk[8] = 8'hff;
    msk[9] = 8'hff;
    mdl = '{default: 0};
    void'($urandom(32'hda94b3a2));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wait_mode(PDMS_ACTIVE);
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 16; i++)
        rd(i[3:0], 1'b1);
    foreach (msk[i])
        wr(i[3:0], 8'($urandom));
    foreach (msk[i])
        if (i != 7 && i != 10)
            rd(i[3:0], 1'b1);
    chk("ind_oe", {7'h00, mdl[8][IND_BIT]}, {7'h00, ind_oe});
    chk("ind_o", {7'h00, mdl[9][IND_BIT]}, {7'h00, ind_o});
    // Every wait code: active to subactive, then direct back through settle
    for (int s = 0; s < 8; s++)
    begin
        wr(ADDR_PWR_A, {1'($urandom), s[2:0], 4'h0});
        wr(ADDR_PWR_B, 8'h60 | (8'($urandom) & 8'h80));
        sleep;
        mode_is(PDMS_SUBACTIVE);
        mdl[10] = 1;
        rd(ADDR_MODE_STAT, 1'b1);
        wr(ADDR_PWR_B, 8'h20 | (8'($urandom) & 8'h80));
        sleep;
        mode_is(PDMS_SETTLE);
        wait_mode(PDMS_ACTIVE);
        t = WU << s;
        chk("settle_ok", 8'h01, {7'h00, n >= t - 2 && n <= t + 3});
        mdl[10] = 0;
    end
    wr(ADDR_IRQ_EN, 8'h0f);
    wr(ADDR_WKP_EN, 8'h00);
    wr(ADDR_PWR_B, 8'h60);
    sleep;
    wr(ADDR_PWR_A, 8'h00);
    wr(ADDR_PWR_B, 8'hc0);
    wr(ADDR_PORT_OUT, 8'($urandom));
    sleep;
    mode_is(PDMS_SUBSLEEP);
    chk("halt", 8'h03, {6'h00, periph_halt, ~cpu_clk_en});
    wkp_l <= 6'h3f;
    repeat (10) @(posedge clk_sys);
    #1 mode_is(PDMS_SUBSLEEP);
    mask_req <= 1'b1;
    k = $urandom % 4;
    irq_l[k] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 chk("irq_pending", 8'h01, {7'h00, irq_pending});
    mode_is(PDMS_SUBSLEEP);
    t = mdl[9];
    wr(ADDR_PORT_OUT, ~t[7:0]);
    mdl[9] = t;
    #1 chk("ind_o", {7'h00, mdl[9][IND_BIT]}, {7'h00, ind_o});
    mask_req <= 1'b0;
    wait_mode(PDMS_SUBACTIVE);
    // The wake pulse is counted by the core one edge after the mode changes
    @(posedge clk_sys);
    #1 chk("wake_cnt", 8'h01, wake_cnt[7:0]);
    irq_l <= 4'h0;
    wkp_l <= 6'h00;
    wr(ADDR_IRQ_FLAG, 8'h00);
    wr(ADDR_WKP_FLAG, 8'h00);
    rd(ADDR_IRQ_FLAG, 1'b1);
    sleep;
    mode_is(PDMS_SUBSLEEP);
    init_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 chk("core_reset", 8'h01, {7'h00, core_reset});
    mode_is(PDMS_INIT);
    for (int i = 0; i < 7; i++)
        mdl[i] = 0;
    rd(ADDR_PWR_B, 1'b1);
    chk("ind_o", {7'h00, mdl[9][IND_BIT]}, {7'h00, ind_o});
    init_n <= 1'b1;
    wait_mode(PDMS_ACTIVE);
    repeat (4) @(posedge clk_sys);
    #1 chk("core_reset", 8'h00, {7'h00, core_reset});
    wr(ADDR_TB_MODE, 8'h0e);
    repeat (SUB_DIV_CYCLES * 5) @(posedge clk_sys);
    rd(ADDR_TB_COUNT, 1'b0);
    chk("tb_count_ok", 8'h01, {7'h00, v >= 8'h04 && v <= 8'h06});
    end_sim;
end
endmodule
